/* File: src/swp_status_protect.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] mode 00: latched writes accepted, pin ignored
// [R2] mode 01 with pin low: writes refused
// [R3] mode 01 with pin high: latched writes accepted
// [R4] mode 10: writes blocked until reset
// [R5] mode 11, lock clear: blocked until reset
// [R6] mode 11, lock set: writes refused forever
// [R7] reset: copy 00 or 01 loads unchanged
// [R8] reset: copy 10 loads 00, 11 unlocked 01
// [R9] reset: copy 11 locked keeps 11
// [R10] config bit 7 picks hold or reset
// [R11] quad enable disables hold and reset roles
// [R12] bits 6:5 drive strength, default full
// [R13] bit 2 picks range or block protection
// [R14] all block locks set on reset
// [R15] host locks 36h, unlocks 39h
// [R16] quad enable turns pins into data lines
// [R17] reserved config bits read zero
module swp_status_protect (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [1:0] cmd_sel,
  input wire logic [7:0] cmd_data,
  input wire logic write_latch,
  input wire logic quad_enable,
  input wire logic wp_pin,
  input wire logic nv_protect_hi,
  input wire logic nv_protect_lo,
  input wire logic nv_perm_lock,
  output logic status_protect_hi,
  output logic status_protect_lo,
  output logic [7:0] pin_drive_protect_config,
  output logic sr_write_done,
  output logic sr_write_refused,
  output logic hold_enable,
  output logic reset_pin_enable,
  output logic wp_active,
  output logic [1:0] output_strength,
  output logic protect_scheme_select,
  output logic [swp_pkg::NUM_BLOCKS-1:0] block_locks
);
  import swp_pkg::*;

  swp_cfg_if cfg_bus();

  logic [1:0] mode;
  logic [1:0] target;
  logic is_sr_write;
  logic write_ok;
  logic block_cmd;
  logic next_hi;
  logic next_lo;
  logic [7:0] next_cfg;
  logic next_done;
  logic next_refused;

  // ==========================================================
  // pin roles and block locks
  swp_pin_func u_pins (
    .clock(clock),
    .srst(srst),
    .wp_pin(wp_pin),
    .cfg(cfg_bus.pins)
  );

  assign cfg_bus.pin_role_reset = pin_drive_protect_config[SR3_PIN_ROLE_BIT]; // [R10]
  assign cfg_bus.quad_enable = quad_enable; // [R11]
  assign hold_enable = cfg_bus.hold_enable;
  assign reset_pin_enable = cfg_bus.reset_pin_enable;
  assign wp_active = cfg_bus.wp_active;

  assign output_strength = pin_drive_protect_config[SR3_STRENGTH_LO +: 2]; // [R12]
  assign protect_scheme_select = pin_drive_protect_config[SR3_SCHEME_BIT]; // [R13]

  assign block_cmd = cmd_valid & write_latch;

  swp_block_locks u_blocks (
    .clock(clock),
    .srst(srst),
    .scheme_sel(protect_scheme_select),
    .lock_req(block_cmd && cmd_opcode == OP_BLOCK_LOCK),
    .unlock_req(block_cmd && cmd_opcode == OP_BLOCK_UNLOCK),
    .block_idx(cmd_data[BLOCK_IDX_W-1:0]),
    .locks(block_locks)
  );

  // ==========================================================
  // write decode and protection check
  assign mode = {status_protect_hi, status_protect_lo};

  always_comb begin
    case (cmd_opcode)
      OP_WRSR1: target = SEL_SR1;
      OP_WRSR2: target = SEL_SR2;
      OP_WRSR3: target = SEL_SR3;
      OP_WRSR_ANY: target = cmd_sel;
      default: target = SEL_NONE;
    endcase
  end

  assign is_sr_write = cmd_valid && target != SEL_NONE;

  always_comb begin
    case (mode)
      MODE_SOFT: write_ok = write_latch; // [R1]
      MODE_HW: write_ok = write_latch & cfg_bus.wp_high; // [R2] [R3]
      // lockdown and otp both refuse; only reset can leave lockdown
      MODE_LOCKDOWN: write_ok = 1'b0; // [R4]
      MODE_LOCK_OR_OTP: write_ok = 1'b0; // [R5] [R6]
      default: write_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // protection and configuration state
  always_comb begin
    next_hi = status_protect_hi;
    next_lo = status_protect_lo;
    next_cfg = pin_drive_protect_config;
    next_done = 1'b0;
    next_refused = 1'b0;
    if (srst) begin
      next_cfg = SR3_RESET; // [R10] [R12] [R13]
      case ({nv_protect_hi, nv_protect_lo})
        MODE_SOFT: {next_hi, next_lo} = MODE_SOFT; // [R7]
        MODE_HW: {next_hi, next_lo} = MODE_HW; // [R7]
        MODE_LOCKDOWN: {next_hi, next_lo} = MODE_SOFT; // [R8]
        MODE_LOCK_OR_OTP: begin
          if (nv_perm_lock) begin
            {next_hi, next_lo} = MODE_LOCK_OR_OTP; // [R9]
          end else begin
            {next_hi, next_lo} = MODE_HW; // [R8]
          end
        end
        default: {next_hi, next_lo} = MODE_SOFT;
      endcase
    end else if (is_sr_write) begin
      if (write_ok) begin
        next_done = 1'b1;
        case (target)
          SEL_SR1: next_lo = cmd_data[SR1_PROT_LO_BIT];
          SEL_SR2: next_hi = cmd_data[SR2_PROT_HI_BIT];
          SEL_SR3: next_cfg = cmd_data & SR3_WRITE_MASK; // [R17]
          default: next_cfg = pin_drive_protect_config;
        endcase
      end else begin
        next_refused = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    status_protect_hi <= next_hi;
    status_protect_lo <= next_lo;
    pin_drive_protect_config <= next_cfg;
    sr_write_done <= next_done;
    sr_write_refused <= next_refused;
  end

  // ==========================================================
  // assertions
  default clocking dflt_clk @(posedge clock);
  endclocking

  default disable iff (srst);

  a_soft_mode_write: assert property ( // [R1]
    is_sr_write && mode == MODE_SOFT && write_latch |=> sr_write_done && !sr_write_refused
  ) else $error("latched write refused in software mode");

  a_hw_pin_block: assert property ( // [R2]
    is_sr_write && mode == MODE_HW && !cfg_bus.wp_high
    |=> sr_write_refused && $stable({status_protect_hi, status_protect_lo, pin_drive_protect_config})
  ) else $error("write taken while pin protects");

  a_hw_pin_open: assert property ( // [R3]
    is_sr_write && mode == MODE_HW && cfg_bus.wp_high && write_latch |=> sr_write_done
  ) else $error("write refused with pin high");

  a_lockdown_hold: assert property ( // [R4]
    is_sr_write && mode == MODE_LOCKDOWN
    |=> sr_write_refused && $stable(pin_drive_protect_config) && mode == MODE_LOCKDOWN
  ) else $error("write taken during reset lockdown");

  a_lock_clear_hold: assert property ( // [R5]
    is_sr_write && mode == MODE_LOCK_OR_OTP && !nv_perm_lock |=> sr_write_refused
  ) else $error("write taken in mode 11 with lock clear");

  a_otp_forever: assert property ( // [R6]
    mode == MODE_LOCK_OR_OTP && nv_perm_lock && is_sr_write
    |=> !sr_write_done ##1 mode == MODE_LOCK_OR_OTP
  ) else $error("otp protection left without reset");

  a_reset_keep: assert property ( // [R7]
    $fell(srst) && !$past(nv_protect_hi)
    |-> mode == {1'b0, $past(nv_protect_lo)}
  ) else $error("reset did not keep software or hardware mode");

  a_reset_change: assert property ( // [R8]
    $fell(srst) && $past(nv_protect_hi) && !($past(nv_protect_lo) && $past(nv_perm_lock))
    |-> mode == (($past(nv_protect_lo)) ? MODE_HW : MODE_SOFT)
  ) else $error("reset lockdown not released correctly");

  a_reset_otp: assert property ( // [R9]
    $fell(srst) && $past(nv_protect_hi) && $past(nv_protect_lo) && $past(nv_perm_lock)
    |-> mode == MODE_LOCK_OR_OTP
  ) else $error("otp mode lost over reset");

  a_pin_role_sel: assert property ( // [R10]
    sr_write_done && $past(target) == SEL_SR3 && !quad_enable
    |-> reset_pin_enable == $past(cmd_data[SR3_PIN_ROLE_BIT]) && hold_enable != reset_pin_enable
  ) else $error("pin role does not follow config bit");

  a_quad_pins_off: assert property ( // [R11] [R16]
    quad_enable |-> !hold_enable && !reset_pin_enable && !wp_active && cfg_bus.wp_high
  ) else $error("pin function active in quad mode");

  a_strength_dflt: assert property ( // [R12]
    $fell(srst) |-> output_strength == STRENGTH_FULL && !pin_drive_protect_config[SR3_PIN_ROLE_BIT]
  ) else $error("config defaults wrong after reset");

  a_scheme_write: assert property ( // [R13]
    sr_write_done && $past(target) == SEL_SR3
    |-> protect_scheme_select == $past(cmd_data[SR3_SCHEME_BIT])
  ) else $error("scheme select not written");

  a_blocks_locked: assert property ( // [R14]
    $fell(srst) |-> block_locks == '1
  ) else $error("block locks not all set after reset");

  a_block_unlock: assert property ( // [R15]
    block_cmd && protect_scheme_select && cmd_opcode == OP_BLOCK_UNLOCK
    |=> !block_locks[$past(cmd_data[BLOCK_IDX_W-1:0])]
  ) else $error("block unlock had no effect");

  a_reserved_zero: assert property ( // [R17]
    (pin_drive_protect_config & ~SR3_WRITE_MASK) == 8'h00
  ) else $error("reserved config bits not zero");

  // an accepted write lands only in its own target; a refusal leaves all state alone
  a_soft_latch_needed: assert property ( // [R1]
    is_sr_write && mode == MODE_SOFT && !write_latch
    |=> sr_write_refused && $stable({status_protect_hi, status_protect_lo, pin_drive_protect_config})
  ) else $error("unlatched write taken in software mode");

  a_hw_latch_needed: assert property ( // [R3]
    is_sr_write && mode == MODE_HW && !write_latch |=> sr_write_refused && !sr_write_done
  ) else $error("unlatched write taken in hardware mode");

  a_otp_no_change: assert property ( // [R5] [R6]
    is_sr_write && mode == MODE_LOCK_OR_OTP
    |=> $stable(pin_drive_protect_config) && mode == MODE_LOCK_OR_OTP
  ) else $error("state changed by write in mode 11");

  a_pulse_exclusive: assert property ( // [R2]
    !(sr_write_done && sr_write_refused)
  ) else $error("write both accepted and refused");

  a_lo_bit_write: assert property ( // [R1]
    sr_write_done && $past(target) == SEL_SR1
    |-> status_protect_lo == $past(cmd_data[SR1_PROT_LO_BIT])
  ) else $error("low protect bit not written");

  a_hi_bit_write: assert property ( // [R1]
    sr_write_done && $past(target) == SEL_SR2
    |-> status_protect_hi == $past(cmd_data[SR2_PROT_HI_BIT])
  ) else $error("high protect bit not written");

  a_strength_write: assert property ( // [R12]
    sr_write_done && $past(target) == SEL_SR3
    |-> output_strength == $past(cmd_data[SR3_STRENGTH_LO +: 2])
  ) else $error("drive strength not written");

  a_scheme_dflt: assert property ( // [R13]
    $fell(srst) |-> !protect_scheme_select
  ) else $error("scheme select not cleared by reset");

  a_scheme_gate: assert property ( // [R13]
    block_cmd && !protect_scheme_select |=> $stable(block_locks)
  ) else $error("block locks changed under range scheme");

  a_block_lock_set: assert property ( // [R15]
    block_cmd && protect_scheme_select && cmd_opcode == OP_BLOCK_LOCK
    |=> block_locks[$past(cmd_data[BLOCK_IDX_W-1:0])]
  ) else $error("block lock had no effect");

  c_soft_write: cover property (
    is_sr_write && mode == MODE_SOFT && write_latch ##1 sr_write_done
  );

  c_hw_refuse: cover property (
    is_sr_write && mode == MODE_HW && !cfg_bus.wp_high ##1 sr_write_refused
  );

  c_enter_lockdown: cover property (
    mode == MODE_SOFT ##1 mode == MODE_LOCKDOWN
  );

  c_block_unlock: cover property (
    block_cmd && protect_scheme_select && cmd_opcode == OP_BLOCK_UNLOCK
  );

  c_otp_refuse: cover property (
    is_sr_write && mode == MODE_LOCK_OR_OTP && nv_perm_lock ##1 sr_write_refused
  );

endmodule

/* File: src/swp_pkg.sv */
package swp_pkg;

  // ==========================================================
  // command opcodes
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_WRSR_ANY = 8'h71;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;

  // ==========================================================
  // status register select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_SR1 = 2'h1;
  localparam logic [1:0] SEL_SR2 = 2'h2;
  localparam logic [1:0] SEL_SR3 = 2'h3;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned SR1_PROT_LO_BIT = 7;
  localparam int unsigned SR2_PROT_HI_BIT = 0;
  localparam int unsigned SR3_PIN_ROLE_BIT = 7;
  localparam int unsigned SR3_STRENGTH_LO = 5;
  localparam int unsigned SR3_SCHEME_BIT = 2;
  localparam logic [7:0] SR3_WRITE_MASK = 8'he4;
  localparam logic [7:0] SR3_RESET = 8'h20;
  localparam logic [1:0] STRENGTH_FULL = 2'h1;

  // ==========================================================
  // protection modes {status_protect_hi, status_protect_lo}
  localparam logic [1:0] MODE_SOFT = 2'h0;
  localparam logic [1:0] MODE_HW = 2'h1;
  localparam logic [1:0] MODE_LOCKDOWN = 2'h2;
  localparam logic [1:0] MODE_LOCK_OR_OTP = 2'h3;

  // ==========================================================
  // individual block locks: 8 Mbit in 64 KB blocks
  localparam int unsigned NUM_BLOCKS = 16;
  localparam int unsigned BLOCK_IDX_W = 4;

endpackage

/* File: src/swp_cfg_if.sv */
`timescale 1ns/1ps
interface swp_cfg_if;
  logic pin_role_reset;
  logic quad_enable;
  logic wp_high;
  logic hold_enable;
  logic reset_pin_enable;
  logic wp_active;

  modport cfg (
    output pin_role_reset,
    output quad_enable,
    input wp_high,
    input hold_enable,
    input reset_pin_enable,
    input wp_active
  );

  modport pins (
    input pin_role_reset,
    input quad_enable,
    output wp_high,
    output hold_enable,
    output reset_pin_enable,
    output wp_active
  );
endinterface

/* File: src/swp_pin_func.sv */
`timescale 1ns/1ps
module swp_pin_func (
  input wire logic clock,
  input wire logic srst,
  input wire logic wp_pin,
  swp_cfg_if.pins cfg
);
  logic wp_meta;
  logic wp_sync;

  // ==========================================================
  // write-protect pin synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= wp_pin;
      wp_sync <= wp_meta;
    end
  end

  // ==========================================================
  // pin roles
  always_comb begin
    // in quad mode the pin is a data line, so it never protects
    cfg.wp_high = cfg.quad_enable | wp_sync; // [R16]
    cfg.wp_active = ~cfg.quad_enable; // [R16]
    cfg.hold_enable = ~cfg.quad_enable & ~cfg.pin_role_reset; // [R10] [R11]
    cfg.reset_pin_enable = ~cfg.quad_enable & cfg.pin_role_reset; // [R10] [R11]
  end
endmodule

/* File: src/swp_block_locks.sv */
`timescale 1ns/1ps
module swp_block_locks (
  input wire logic clock,
  input wire logic srst,
  input wire logic scheme_sel,
  input wire logic lock_req,
  input wire logic unlock_req,
  input wire logic [swp_pkg::BLOCK_IDX_W-1:0] block_idx,
  output logic [swp_pkg::NUM_BLOCKS-1:0] locks
);
  import swp_pkg::*;

  logic [NUM_BLOCKS-1:0] next_locks;

  // ==========================================================
  // per-block lock bits
  always_comb begin
    next_locks = locks;
    if (srst) begin
      next_locks = '1; // [R14]
    end else if (scheme_sel) begin
      // commands only matter while the per-block scheme is chosen
      if (lock_req) begin
        next_locks[block_idx] = 1'b1; // [R15]
      end else if (unlock_req) begin
        next_locks[block_idx] = 1'b0; // [R15]
      end
    end
  end

  always_ff @(posedge clock) begin
    locks <= next_locks;
  end
endmodule

/* File: test/swp_host_model.sv */
`timescale 1ns/1ps
module swp_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [1:0] cmd_sel,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_sel = 2'h0;
    cmd_data = 8'h00;
  end

  // ==========================================================
  // one command per call
  // released lines go to the inverse so a stale value never passes for a live one
  task automatic send(input logic [7:0] op, input logic [1:0] sel, input logic [7:0] data);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_sel <= sel;
    cmd_data <= data;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_sel <= ~sel;
    cmd_data <= ~data;
  endtask
endmodule

/* File: test/test_status_write_protect_cfg.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_status_write_protect_cfg;
  import swp_pkg::*;
  logic clock, srst, write_latch, quad_enable, wp_pin, nv_hi, nv_lo, nv_lock;
  logic cmd_valid, protect_hi, protect_lo, done, refused, hold_en, rst_en, wp_act, scheme;
  logic [7:0] cmd_opcode, cmd_data, cfg;
  logic [1:0] cmd_sel, strength;
  logic [NUM_BLOCKS-1:0] locks;
  int fail_count = 0;
  int tests_run = 0;

  swp_host_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_sel(cmd_sel), .cmd_data(cmd_data));
  swp_status_protect DUT (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_sel(cmd_sel), .cmd_data(cmd_data), .write_latch(write_latch), .quad_enable(quad_enable),
    .wp_pin(wp_pin), .nv_protect_hi(nv_hi), .nv_protect_lo(nv_lo), .nv_perm_lock(nv_lock),
    .status_protect_hi(protect_hi), .status_protect_lo(protect_lo), .pin_drive_protect_config(cfg),
    .sr_write_done(done), .sr_write_refused(refused), .hold_enable(hold_en), .reset_pin_enable(rst_en),
    .wp_active(wp_act), .output_strength(strength), .protect_scheme_select(scheme), .block_locks(locks));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // three edges cover the two-flop pin synchroniser
  task automatic drive(input logic latch, input logic quad, input logic wp);
    @(posedge clock);
    write_latch <= latch;
    quad_enable <= quad;
    wp_pin <= wp;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic rst(input logic hi, input logic lo, input logic lk);
    @(posedge clock);
    srst <= 1'b1;
    nv_hi <= hi;
    nv_lo <= lo;
    nv_lock <= lk;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // pulse code is {done, refused}
  task automatic wr(input logic [7:0] op, input logic [1:0] sel, input logic [7:0] d, input logic [1:0] exp);
    u_host.send(op, sel, d);
    #1;
    `CHK({done, refused}, exp)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reload();
    logic [2:0] nv [5] = '{3'b000, 3'b010, 3'b100, 3'b110, 3'b111};
    logic [1:0] exp [5] = '{2'b00, 2'b01, 2'b00, 2'b01, 2'b11};
    for (int i = 0; i < 5; i++) begin
      rst(nv[i][2], nv[i][1], nv[i][0]);
      `CHK({protect_hi, protect_lo}, exp[i])
    end
    `CHK(cfg, 8'h20)
    `CHK(locks, {NUM_BLOCKS{1'b1}})
    $display("test reload done");
  endtask

  task automatic t_soft();
    rst(1'b1, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b0);
    wr(OP_WRSR3, SEL_NONE, 8'hff, 2'b01);
    drive(1'b1, 1'b0, 1'b0);
    wr(OP_WRSR3, SEL_NONE, 8'hff, 2'b10);
    `CHK(cfg, 8'he4)
    `CHK({strength, scheme}, 3'b111)
    $display("test soft done");
  endtask

  task automatic t_hw();
    rst(1'b0, 1'b1, 1'b1);
    drive(1'b1, 1'b0, 1'b0);
    wr(OP_WRSR3, SEL_NONE, 8'h80, 2'b01);
    `CHK(cfg, 8'h20)
    drive(1'b0, 1'b0, 1'b1);
    wr(OP_WRSR3, SEL_NONE, 8'h80, 2'b01);
    drive(1'b1, 1'b0, 1'b1);
    wr(OP_WRSR_ANY, SEL_SR3, 8'h80, 2'b10);
    wr(OP_WRSR_ANY, SEL_NONE, 8'h00, 2'b00);
    `CHK({cfg, strength, hold_en, rst_en, wp_act}, {8'h80, 2'b00, 3'b011})
    wr(OP_WRSR_ANY, SEL_SR1, 8'h00, 2'b10);
    `CHK({protect_hi, protect_lo}, 2'b00)
    drive(1'b1, 1'b1, 1'b1);
    `CHK({hold_en, rst_en, wp_act}, 3'b000)
    $display("test hardware done");
  endtask

  task automatic t_lockdown();
    rst(1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b1);
    wr(OP_WRSR2, SEL_NONE, 8'h01, 2'b10);
    wr(OP_WRSR1, SEL_NONE, 8'h80, 2'b01);
    `CHK({protect_hi, protect_lo}, 2'b10)
    rst(1'b0, 1'b0, 1'b0);
    wr(OP_WRSR1, SEL_NONE, 8'h80, 2'b10);
    wr(OP_WRSR_ANY, SEL_SR2, 8'h01, 2'b10);
    wr(OP_WRSR3, SEL_NONE, 8'h04, 2'b01);
    `CHK({protect_hi, protect_lo, scheme}, 3'b110)
    rst(1'b1, 1'b1, 1'b1);
    wr(OP_WRSR1, SEL_NONE, 8'h00, 2'b01);
    drive(1'b1, 1'b0, 1'b0);
    wr(OP_WRSR2, SEL_NONE, 8'h00, 2'b01);
    $display("test lockdown done");
  endtask

  task automatic t_blocks();
    rst(1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    u_host.send(OP_BLOCK_UNLOCK, SEL_NONE, 8'h05);
    #1;
    `CHK(locks, 16'hffff)
    wr(OP_WRSR3, SEL_NONE, 8'h04, 2'b10);
    u_host.send(OP_BLOCK_UNLOCK, SEL_NONE, 8'h05);
    #1;
    `CHK(locks, 16'hffdf)
    u_host.send(OP_BLOCK_UNLOCK, SEL_NONE, 8'h0f);
    u_host.send(OP_BLOCK_LOCK, SEL_NONE, 8'h05);
    #1;
    `CHK(locks, 16'h7fff)
    drive(1'b0, 1'b0, 1'b0);
    u_host.send(OP_BLOCK_UNLOCK, SEL_NONE, 8'h00);
    #1;
    `CHK(locks, 16'h7fff)
    rst(1'b0, 1'b0, 1'b0);
    `CHK({locks, scheme}, {16'hffff, 1'b0})
    $display("test blocks done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    write_latch = 1'b0;
    quad_enable = 1'b0;
    wp_pin = 1'b0;
    nv_hi = 1'b0;
    nv_lo = 1'b0;
    nv_lock = 1'b0;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    t_reload();
    t_soft();
    t_hw();
    t_lockdown();
    t_blocks();
    test_done();
  end

  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule
